// ### core/kms_pkg.sv
// Constants, types and state layout for the keypad matrix scanner
package kms_pkg;
    localparam int ROWS = 8;
    localparam int COLS = 12;
    localparam int NCODE = 4;
    localparam int DEPTH = 8;
    localparam int WAIT_SCALE = 4;
    localparam int DED_FIRST = 2;
    localparam int DED_ROW_OFS = 8;
    localparam logic [5:0] IDX_SETTLE = 6'h01;
    localparam logic [5:0] IDX_BOUNCE = 6'h02;
    localparam logic [5:0] IDX_SIZE = 6'h03;
    localparam logic [5:0] IDX_DEDCFG = 6'h04;
    localparam logic [5:0] IDX_CODE0 = 6'h0B;
    localparam logic [5:0] IDX_CODE3 = 6'h0E;
    localparam logic [5:0] IDX_EVT = 6'h10;
    localparam logic [5:0] IDX_STAT = 6'h11;
    localparam logic [5:0] IDX_CTRL = 6'h12;
    localparam logic [7:0] RST_SETTLE = 8'hA3;
    localparam logic [7:0] RST_BOUNCE = 8'hA3;
    localparam logic [7:0] RST_SIZE = 8'h00;
    localparam logic [15:0] RST_DED = 16'hFFFF;
    localparam logic [3:0] SIZE_MIN = 4'h2;
    localparam logic [3:0] ROW_MAX = 4'h8;
    localparam logic [3:0] COL_MAX = 4'hC;
    localparam logic [3:0] SFK_COL = 4'hC;
    localparam logic [6:0] CODE_NONE = 7'h7F;
    localparam logic [7:0] EVT_EMPTY = 8'hFF;
    localparam int STAT_REL = 0;
    localparam int STAT_LOST = 1;
    localparam int CTRL_REL_EN = 0;
    localparam int CTRL_FLUSH = 1;

    typedef enum logic [2:0] {
        ST_IDLE, ST_SETTLE, ST_SFK, ST_COL, ST_DED, ST_CMP, ST_GAP, ST_EVT
    } kms_state_t;

    typedef logic [6:0] kms_code_t;

    typedef struct packed {
        kms_state_t st;
        logic [3:0] idx;
        logic [9:0] cnt;
        logic [2:0] ei;
        logic [7:0] sfk;
        logic [3:0][6:0] cur;
        logic [2:0] cur_n;
        logic [3:0][6:0] prev;
        logic [2:0] prev_n;
        logic have_prev;
        logic [3:0][6:0] stab;
        logic [2:0] stab_n;
        logic [19:0] snap;
        logic [7:0] settle;
        logic [7:0] bounce;
        logic [7:0] size;
        logic [15:0] ded;
        logic [7:0][7:0] fifo;
        logic [2:0] wp;
        logic [2:0] rp;
        logic [3:0] fcnt;
        logic lost;
        logic rel;
        logic rel_en;
        logic irq;
        logic [11:0] col_drv;
        logic [11:0] col_oe;
        logic [7:0] row_own;
        logic [11:0] col_own;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic pop_pend;
    } kms_regs_t;
endpackage

// ### core/kms_top.sv
// Keypad matrix scanner with APB register slave
//
// Chosen here: the register addresses and register access over APB.
module kms_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    // Keypad lines
    input wire logic [kms_pkg::ROWS-1:0] row_line,
    input wire logic [kms_pkg::COLS-1:0] col_line_in,
    output logic [kms_pkg::COLS-1:0] col_line_out,
    output logic [kms_pkg::COLS-1:0] col_line_oe,
    // Line ownership towards GPIO and release event
    output logic [kms_pkg::ROWS-1:0] row_owned,
    output logic [kms_pkg::COLS-1:0] col_owned,
    output logic key_release_irq
);
    kms_pkg::kms_regs_t s_r;
    kms_pkg::kms_regs_t s_nxt;
    logic [3:0] nrow;
    logic [3:0] ncol;
    logic mat_en;
    logic [7:0] row_mat;
    logic [7:0] row_ded;
    logic [11:0] col_mat;
    logic [11:0] col_ded;
    logic [19:0] pressed;
    logic trig;
    logic setup;
    logic done;
    logic [5:0] aidx;
    logic hit;

    assign nrow = s_r.size[7:4];
    assign ncol = s_r.size[3:0];
    // Codes 0 and 1 leave the matrix off rather than half-configured
    assign mat_en = (nrow >= kms_pkg::SIZE_MIN) && (nrow <= kms_pkg::ROW_MAX)
                    && (ncol >= kms_pkg::SIZE_MIN) && (ncol <= kms_pkg::COL_MAX);

    genvar g;
    generate
        for (g = 0; g < kms_pkg::ROWS; g++) begin : g_row
            assign row_mat[g] = mat_en && (4'(g) < nrow);
            if (g >= kms_pkg::DED_FIRST) begin : g_d
                assign row_ded[g] = !s_r.ded[g+kms_pkg::DED_ROW_OFS] && !row_mat[g];
            end else begin : g_n
                assign row_ded[g] = 1'b0;
            end
        end
        for (g = 0; g < kms_pkg::COLS; g++) begin : g_col
            assign col_mat[g] = mat_en && (4'(g) < ncol);
            if (g >= kms_pkg::DED_FIRST) begin : g_d
                assign col_ded[g] = !s_r.ded[g-kms_pkg::DED_FIRST] && !col_mat[g];
            end else begin : g_n
                assign col_ded[g] = 1'b0;
            end
        end
    endgenerate

    // A change in the pressed pattern, press or release, wakes the scanner
    assign pressed = {~col_line_in & col_ded, ~row_line & (row_mat | row_ded)};
    assign trig = (pressed != s_r.snap);
    assign setup = psel && !penable;
    assign done = psel && penable && s_r.pready;
    assign aidx = paddr[7:2];
    assign hit = (paddr[1:0] == 2'b00) && ((aidx == kms_pkg::IDX_SETTLE)
                 || (aidx == kms_pkg::IDX_BOUNCE) || (aidx == kms_pkg::IDX_SIZE)
                 || (aidx == kms_pkg::IDX_DEDCFG) || (aidx == kms_pkg::IDX_EVT)
                 || (aidx == kms_pkg::IDX_STAT) || (aidx == kms_pkg::IDX_CTRL)
                 || ((aidx >= kms_pkg::IDX_CODE0) && (aidx <= kms_pkg::IDX_CODE3)));

    function automatic kms_pkg::kms_regs_t kms_add(kms_pkg::kms_regs_t a, kms_pkg::kms_code_t c);
        kms_pkg::kms_regs_t b;
        b = a;
        if (b.cur_n < 3'(kms_pkg::NCODE)) begin
            b.cur[b.cur_n[1:0]] = c;
            b.cur_n = b.cur_n + 3'd1;
        end
        return b;
    endfunction

    function automatic kms_pkg::kms_regs_t kms_start(kms_pkg::kms_regs_t a);
        kms_pkg::kms_regs_t b;
        b = a;
        b.st = kms_pkg::ST_SFK;
        b.sfk = 8'h00;
        b.cur_n = 3'd0;
        for (int i = 0; i < kms_pkg::NCODE; i++) begin
            b.cur[i] = kms_pkg::CODE_NONE;
        end
        return b;
    endfunction

    function automatic kms_pkg::kms_regs_t kms_push(kms_pkg::kms_regs_t a, logic [7:0] e);
        kms_pkg::kms_regs_t b;
        b = a;
        // When full the newest event is dropped and flagged as lost
        if (b.fcnt < 4'(kms_pkg::DEPTH)) begin
            b.fifo[b.wp] = e;
            b.wp = b.wp + 3'd1;
            b.fcnt = b.fcnt + 4'd1;
        end else begin
            b.lost = 1'b1;
        end
        if (e[7]) begin
            b.rel = 1'b1;
        end
        return b;
    endfunction

    function automatic logic kms_in(kms_pkg::kms_code_t c, logic [3:0][6:0] set, logic [2:0] n);
        logic f;
        f = 1'b0;
        for (int i = 0; i < kms_pkg::NCODE; i++) begin
            if ((3'(i) < n) && (set[i] == c)) begin
                f = 1'b1;
            end
        end
        return f;
    endfunction

    always_comb begin
        logic [7:0] rd;
        logic [1:0] k;
        logic same;
        logic [3:0] cx;
        logic [3:0] nr_n;
        logic [3:0] nc_n;
        logic en_n;
        logic [7:0] rm_n;
        logic [11:0] cm_n;
        rd = 8'h00;
        k = 2'd0;
        same = 1'b0;
        cx = 4'h0;
        nr_n = 4'h0;
        nc_n = 4'h0;
        en_n = 1'b0;
        rm_n = 8'h00;
        cm_n = 12'h000;
        s_nxt = s_r;
        // APB: read data is captured in the setup cycle, zero wait states
        s_nxt.pready = setup;
        s_nxt.pslverr = setup && !hit;
        s_nxt.pop_pend = 1'b0;
        if (aidx >= kms_pkg::IDX_CODE0 && aidx <= kms_pkg::IDX_CODE3) begin
            cx = 4'(aidx - kms_pkg::IDX_CODE0);
        end
        unique case (aidx)
            kms_pkg::IDX_SETTLE: rd = s_r.settle;
            kms_pkg::IDX_BOUNCE: rd = s_r.bounce;
            kms_pkg::IDX_SIZE: rd = s_r.size;
            kms_pkg::IDX_EVT: rd = (s_r.fcnt != 4'd0) ? s_r.fifo[s_r.rp] : kms_pkg::EVT_EMPTY;
            kms_pkg::IDX_STAT: rd = {6'h00, s_r.lost, s_r.rel};
            kms_pkg::IDX_CTRL: rd = {7'h00, s_r.rel_en};
            default: begin
                if (cx < 4'(s_r.stab_n) && aidx >= kms_pkg::IDX_CODE0) begin
                    rd = {(cx + 4'd1 < 4'(s_r.stab_n)), s_r.stab[cx[1:0]]};
                end else begin
                    rd = {1'b0, kms_pkg::CODE_NONE};
                end
            end
        endcase
        if (setup) begin
            s_nxt.prdata = (!hit) ? 32'h0000_0000 : (aidx == kms_pkg::IDX_DEDCFG)
                           ? {16'h0000, s_r.ded} : {24'h00_0000, rd};
            s_nxt.pop_pend = hit && !pwrite && (aidx == kms_pkg::IDX_EVT)
                             && (s_r.fcnt != 4'd0);
        end else if (done) begin
            s_nxt.prdata = 32'h0000_0000;
        end
        if (done && s_r.pop_pend) begin
            s_nxt.rp = s_r.rp + 3'd1;
            s_nxt.fcnt = s_r.fcnt - 4'd1;
        end
        if (done && pwrite && !s_r.pslverr) begin
            unique case (aidx)
                kms_pkg::IDX_SETTLE: s_nxt.settle = pwdata[7:0];
                kms_pkg::IDX_BOUNCE: s_nxt.bounce = pwdata[7:0];
                kms_pkg::IDX_SIZE: s_nxt.size = pwdata[7:0];
                kms_pkg::IDX_DEDCFG: s_nxt.ded = pwdata[15:0];
                kms_pkg::IDX_STAT: begin
                    s_nxt.rel = s_r.rel && !pwdata[kms_pkg::STAT_REL];
                    s_nxt.lost = s_r.lost && !pwdata[kms_pkg::STAT_LOST];
                end
                kms_pkg::IDX_CTRL: begin
                    s_nxt.rel_en = pwdata[kms_pkg::CTRL_REL_EN];
                    if (pwdata[kms_pkg::CTRL_FLUSH]) begin
                        s_nxt.rp = 3'd0;
                        s_nxt.wp = 3'd0;
                        s_nxt.fcnt = 4'd0;
                    end
                end
                default: begin
                end
            endcase
        end
        // Scanner; pushes come after the clears so a new event wins
        unique case (s_r.st)
            kms_pkg::ST_IDLE: begin
                if (trig) begin
                    s_nxt.have_prev = 1'b0;
                    if (s_r.settle == 8'h00) begin
                        s_nxt = kms_start(s_nxt);
                    end else begin
                        s_nxt.st = kms_pkg::ST_SETTLE;
                        s_nxt.cnt = 10'(kms_pkg::WAIT_SCALE * s_r.settle) - 10'd1;
                    end
                end
            end
            kms_pkg::ST_SETTLE, kms_pkg::ST_GAP: begin
                if (s_r.cnt == 10'd0) begin
                    s_nxt = kms_start(s_nxt);
                end else begin
                    s_nxt.cnt = s_r.cnt - 10'd1;
                end
            end
            kms_pkg::ST_SFK: begin
                for (int r = 0; r < kms_pkg::ROWS; r++) begin
                    if (row_mat[r] && !row_line[r]) begin
                        s_nxt.sfk[r] = 1'b1;
                        s_nxt = kms_add(s_nxt, {3'(r), kms_pkg::SFK_COL});
                    end
                end
                s_nxt.idx = 4'h0;
                s_nxt.st = mat_en ? kms_pkg::ST_COL : kms_pkg::ST_DED;
            end
            kms_pkg::ST_COL: begin
                // A ghost corner pulls its row low too and is reported like a press
                for (int r = 0; r < kms_pkg::ROWS; r++) begin
                    if (row_mat[r] && !s_r.sfk[r] && !row_line[r]) begin
                        s_nxt = kms_add(s_nxt, {3'(r), s_r.idx});
                    end
                end
                if (s_r.idx == ncol - 4'h1) begin
                    s_nxt.st = kms_pkg::ST_DED;
                end else begin
                    s_nxt.idx = s_r.idx + 4'h1;
                end
            end
            kms_pkg::ST_DED: begin
                for (int r = 0; r < kms_pkg::ROWS; r++) begin
                    if (row_ded[r] && !row_line[r]) begin
                        s_nxt = kms_add(s_nxt, {3'(r), 4'h0});
                    end
                end
                for (int c = 0; c < kms_pkg::COLS; c++) begin
                    if (col_ded[c] && !col_line_in[c]) begin
                        s_nxt = kms_add(s_nxt, {3'h0, 4'(c)});
                    end
                end
                s_nxt.st = kms_pkg::ST_CMP;
            end
            kms_pkg::ST_CMP: begin
                same = s_r.have_prev && (s_r.cur == s_r.prev) && (s_r.cur_n == s_r.prev_n);
                if (same) begin
                    s_nxt.st = kms_pkg::ST_EVT;
                    s_nxt.ei = 3'd0;
                end else begin
                    s_nxt.prev = s_r.cur;
                    s_nxt.prev_n = s_r.cur_n;
                    s_nxt.have_prev = 1'b1;
                    if (s_r.bounce == 8'h00) begin
                        s_nxt = kms_start(s_nxt);
                    end else begin
                        s_nxt.st = kms_pkg::ST_GAP;
                        s_nxt.cnt = 10'(kms_pkg::WAIT_SCALE * s_r.bounce) - 10'd1;
                    end
                end
            end
            kms_pkg::ST_EVT: begin
                k = s_r.ei[1:0];
                if (!s_r.ei[2]) begin
                    if ((3'(k) < s_r.stab_n) && !kms_in(s_r.stab[k], s_r.cur, s_r.cur_n)) begin
                        s_nxt = kms_push(s_nxt, {1'b1, s_r.stab[k]});
                    end
                end else if ((3'(k) < s_r.cur_n)
                             && !kms_in(s_r.cur[k], s_r.stab, s_r.stab_n)) begin
                    s_nxt = kms_push(s_nxt, {1'b0, s_r.cur[k]});
                end
                s_nxt.ei = s_r.ei + 3'd1;
                if (s_r.ei == 3'd7) begin
                    s_nxt.stab = s_r.cur;
                    s_nxt.stab_n = s_r.cur_n;
                    s_nxt.snap = pressed;
                    s_nxt.st = kms_pkg::ST_IDLE;
                end
            end
        endcase
        s_nxt.irq = s_nxt.rel && s_nxt.rel_en;
        s_nxt.col_drv = 12'h000;
        // Masks from the setup taking effect now, so line drive never lags a size write
        nr_n = s_nxt.size[7:4];
        nc_n = s_nxt.size[3:0];
        en_n = (nr_n >= kms_pkg::SIZE_MIN) && (nr_n <= kms_pkg::ROW_MAX)
               && (nc_n >= kms_pkg::SIZE_MIN) && (nc_n <= kms_pkg::COL_MAX);
        rm_n = en_n ? 8'((9'h001 << nr_n) - 9'h001) : 8'h00;
        cm_n = en_n ? 12'((13'h0001 << nc_n) - 13'h0001) : 12'h000;
        s_nxt.row_own = rm_n | ~{s_nxt.ded[15:10], 2'b11};
        s_nxt.col_own = cm_n | ~{s_nxt.ded[9:0], 2'b11};
        if (s_nxt.st == kms_pkg::ST_IDLE) begin
            s_nxt.col_oe = cm_n;
        end else if (s_nxt.st == kms_pkg::ST_COL) begin
            s_nxt.col_oe = (12'h001 << s_nxt.idx) & cm_n;
        end else begin
            s_nxt.col_oe = 12'h000;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
            s_r.st <= kms_pkg::ST_IDLE;
            s_r.settle <= kms_pkg::RST_SETTLE;
            s_r.bounce <= kms_pkg::RST_BOUNCE;
            s_r.size <= kms_pkg::RST_SIZE;
            s_r.ded <= kms_pkg::RST_DED;
            s_r.cur <= {kms_pkg::NCODE{kms_pkg::CODE_NONE}};
            s_r.prev <= {kms_pkg::NCODE{kms_pkg::CODE_NONE}};
            s_r.stab <= {kms_pkg::NCODE{kms_pkg::CODE_NONE}};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign prdata = s_r.prdata;
    assign col_line_out = s_r.col_drv;
    assign col_line_oe = s_r.col_oe;
    assign row_owned = s_r.row_own;
    assign col_owned = s_r.col_own;
    assign key_release_irq = s_r.irq;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence s_settle_4;
        (s_r.st == kms_pkg::ST_SETTLE) [*4];
    endsequence
    sequence s_enter_settle_1;
        (s_r.st == kms_pkg::ST_IDLE) && trig && (s_r.settle == 8'h01);
    endsequence

    property p_idle_cols;
        (s_r.st == kms_pkg::ST_IDLE) |-> (col_line_oe == col_mat) && (col_line_out == 12'h000);
    endproperty
    a_idle_cols: assert property (p_idle_cols) else $error("idle columns not low");

    property p_sfk_hiz;
        (s_r.st == kms_pkg::ST_SFK) |-> (col_line_oe == 12'h000);
    endproperty
    a_sfk_hiz: assert property (p_sfk_hiz) else $error("columns driven in special pass");

    property p_col_onehot;
        (s_r.st == kms_pkg::ST_COL) |-> $onehot(col_line_oe) && col_line_oe[s_r.idx];
    endproperty
    a_col_onehot: assert property (p_col_onehot) else $error("column drive not one-hot");

    property p_settle_len;
        s_enter_settle_1 |=> s_settle_4 ##1 (s_r.st == kms_pkg::ST_SFK);
    endproperty
    a_settle_len: assert property (p_settle_len) else $error("settle length wrong");

    property p_zero_wait;
        (s_r.st == kms_pkg::ST_IDLE) && trig && (s_r.settle == 8'h00)
            |=> (s_r.st == kms_pkg::ST_SFK);
    endproperty
    a_zero_wait: assert property (p_zero_wait) else $error("zero settle waited");

    property p_first_col;
        (s_r.st == kms_pkg::ST_SFK) && mat_en |=> (s_r.st == kms_pkg::ST_COL) && (s_r.idx == 4'h0);
    endproperty
    a_first_col: assert property (p_first_col) else $error("scan not from column 0");

    property p_free_lines;
        ((col_line_oe & ~col_owned) == 12'h000) && (col_owned == (col_mat | col_ded)
            || $changed(s_r.size) || $changed(s_r.ded) || $past(!rst_b));
    endproperty
    a_free_lines: assert property (p_free_lines) else $error("free line disturbed");

    property p_stop_same;
        (s_r.st == kms_pkg::ST_CMP) && s_r.have_prev && (s_r.cur == s_r.prev)
            && (s_r.cur_n == s_r.prev_n) |=> (s_r.st == kms_pkg::ST_EVT) ##8 (s_r.st == kms_pkg::ST_IDLE);
    endproperty
    a_stop_same: assert property (p_stop_same) else $error("scan did not stop");

    property p_rescan;
        (s_r.st == kms_pkg::ST_CMP) && !s_r.have_prev |=> (s_r.st != kms_pkg::ST_EVT)
            && (s_r.st != kms_pkg::ST_IDLE);
    endproperty
    a_rescan: assert property (p_rescan) else $error("single scan accepted");

    property p_release_irq;
        (s_r.st == kms_pkg::ST_EVT) && s_r.rel_en && (s_nxt.wp != s_r.wp) && s_nxt.fifo[s_r.wp][7]
            |=> ##1 key_release_irq;
    endproperty
    a_release_irq: assert property (p_release_irq) else $error("release irq missing");

    property p_max_codes;
        s_r.cur_n <= 3'(kms_pkg::NCODE) && s_r.fcnt <= 4'(kms_pkg::DEPTH);
    endproperty
    a_max_codes: assert property (p_max_codes) else $error("code or event count overflow");
endmodule

// ### testbench/kms_keys.sv
// Behavioural key matrix with special and dedicated keys on pulled-up lines
module kms_keys (
    // Column drive from the scanner
    input wire logic [kms_pkg::COLS-1:0] col_oe,
    // Key state from the bench
    input wire logic [kms_pkg::ROWS-1:0][kms_pkg::COLS-1:0] key,
    input wire logic [kms_pkg::ROWS-1:0] sfk,
    input wire logic [kms_pkg::ROWS-1:0] ded_row,
    input wire logic [kms_pkg::COLS-1:0] ded_col,
    // Pin levels seen by the scanner
    output logic [kms_pkg::ROWS-1:0] row_line,
    output logic [kms_pkg::COLS-1:0] col_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [kms_pkg::ROWS-1:0] row_hop;
    logic [kms_pkg::COLS-1:0] col_low;
    // One extra hop through closed switches, enough for a ghost corner
    always_comb begin
        row_hop = sfk;
        for (int r = 0; r < kms_pkg::ROWS; r++)
            row_hop[r] = row_hop[r] | (|(key[r] & col_oe));
        col_low = col_oe;
        for (int r = 0; r < kms_pkg::ROWS; r++)
            if (row_hop[r])
                col_low = col_low | key[r];
        // Released lines float back to the pull-up level
        for (int r = 0; r < kms_pkg::ROWS; r++)
            row_line[r] = ~(sfk[r] | ded_row[r] | (|(key[r] & col_low)));
        col_in = ~(col_oe | ded_col);
    end
endmodule

// ### testbench/keypad_matrix_scanner_bench.sv
// Self-checking bench for the keypad matrix scanner
module keypad_matrix_scanner_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic pready, pslverr, irq;
    logic [31:0] prdata, rd;
    logic err_bit;
    logic [7:0] row_line, row_owned;
    logic [11:0] col_in, col_out, col_oe, col_owned;
    logic [7:0][11:0] key = '0;
    logic [7:0] sfk = 8'h00;
    logic [7:0] ded_row = 8'h00;
    logic [11:0] ded_col = 12'h000;
    int err_total = 0;
    int check_count = 0;
    kms_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .row_line(row_line), .col_line_in(col_in),
        .col_line_out(col_out), .col_line_oe(col_oe), .row_owned(row_owned),
        .col_owned(col_owned), .key_release_irq(irq));
    kms_keys keys (.col_oe(col_oe), .key(key), .sfk(sfk), .ded_row(ded_row),
        .ded_col(ded_col), .row_line(row_line), .col_in(col_in));
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic finish_test;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            err_total++;
        end
        rd = prdata;
        err_bit = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [5:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        cmp(rd, exp);
    endtask
    // Scans take a data-dependent time, so poll under a bound
    task automatic poll(input logic [5:0] idx, input logic [31:0] exp);
        int n;
        n = 0;
        do begin
            apb(1'b0, idx, 32'h0);
            n++;
        end while (rd !== exp && n < 60);
        cmp(rd, exp);
    endtask
    function automatic logic [31:0] code(input int r, input int c, input logic m);
        return {24'h0, m, r[2:0], c[3:0]};
    endfunction
    initial begin
        #200000;
        err_total++;
        finish_test;
    end
    initial begin
        int r;
        int c;
        void'($urandom(30667));
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        rchk(kms_pkg::IDX_SETTLE, 32'hA3);
        rchk(kms_pkg::IDX_BOUNCE, 32'hA3);
        rchk(kms_pkg::IDX_CODE0, 32'h7F);
        rchk(kms_pkg::IDX_EVT, 32'hFF);
        apb(1'b0, 6'h3F, 32'h0);
        cmp({31'h0, err_bit}, 32'h1);
        apb(1'b1, kms_pkg::IDX_SIZE, 32'h11);
        repeat (3) @(posedge clk_sys);
        cmp({20'h0, col_oe}, 32'h0);
        apb(1'b1, kms_pkg::IDX_SETTLE, 32'h1);
        apb(1'b1, kms_pkg::IDX_BOUNCE, 32'h1);
        apb(1'b1, kms_pkg::IDX_SIZE, 32'h22);
        apb(1'b1, kms_pkg::IDX_CTRL, 32'h1);
        repeat (4) @(posedge clk_sys);
        cmp({20'h0, col_oe}, 32'h3);
        cmp({20'h0, col_out}, 32'h0);
        cmp({24'h0, row_owned}, 32'h3);
        cmp({20'h0, col_owned}, 32'h3);
        key[1][0] <= 1'b1;
        poll(kms_pkg::IDX_CODE0, code(1, 0, 0));
        poll(kms_pkg::IDX_EVT, 32'h10);
        key[1][0] <= 1'b0;
        poll(kms_pkg::IDX_CODE0, 32'h7F);
        poll(kms_pkg::IDX_EVT, 32'h90);
        cmp({31'h0, irq}, 32'h1);
        apb(1'b1, kms_pkg::IDX_STAT, 32'h1);
        repeat (2) @(posedge clk_sys);
        cmp({31'h0, irq}, 32'h0);
        apb(1'b1, kms_pkg::IDX_DEDCFG, 32'hFBFE);
        repeat (3) @(posedge clk_sys);
        cmp({24'h0, row_owned}, 32'h7);
        cmp({20'h0, col_owned}, 32'h7);
        ded_row[2] <= 1'b1;
        poll(kms_pkg::IDX_CODE0, code(2, 0, 0));
        ded_row[2] <= 1'b0;
        poll(kms_pkg::IDX_CODE0, 32'h7F);
        ded_col[2] <= 1'b1;
        poll(kms_pkg::IDX_CODE0, code(0, 2, 0));
        ded_col[2] <= 1'b0;
        poll(kms_pkg::IDX_CODE0, 32'h7F);
        apb(1'b1, kms_pkg::IDX_DEDCFG, 32'hFFFF);
        apb(1'b1, kms_pkg::IDX_SIZE, 32'h8C);
        repeat (4) @(posedge clk_sys);
        cmp({20'h0, col_oe}, 32'hFFF);
        sfk[5] <= 1'b1;
        poll(kms_pkg::IDX_CODE0, code(5, 12, 0));
        // A key on a grounded row changes no line, so a key on another row wakes the scan
        key[5][3] <= 1'b1;
        key[6][4] <= 1'b1;
        poll(kms_pkg::IDX_CODE0 + 6'h1, code(6, 4, 0));
        sfk <= 8'h00;
        key[6][4] <= 1'b0;
        poll(kms_pkg::IDX_CODE0, code(5, 3, 0));
        key <= '0;
        poll(kms_pkg::IDX_CODE0, 32'h7F);
        key[0][0] <= 1'b1;
        key[0][2] <= 1'b1;
        key[3][2] <= 1'b1;
        poll(kms_pkg::IDX_CODE3, code(3, 2, 0));
        rchk(kms_pkg::IDX_CODE0, code(0, 0, 1));
        rchk(kms_pkg::IDX_CODE0 + 6'h1, code(3, 0, 1));
        rchk(kms_pkg::IDX_CODE0 + 6'h2, code(0, 2, 1));
        key <= '0;
        poll(kms_pkg::IDX_CODE0, 32'h7F);
        // Zero settle and zero interval take the no-wait paths
        apb(1'b1, kms_pkg::IDX_SETTLE, 32'h0);
        apb(1'b1, kms_pkg::IDX_BOUNCE, 32'h0);
        rchk(kms_pkg::IDX_SETTLE, 32'h0);
        repeat (6) begin
            r = $urandom_range(7);
            c = $urandom_range(11);
            key[r][c] <= 1'b1;
            poll(kms_pkg::IDX_CODE0, code(r, c, 0));
            key <= '0;
            poll(kms_pkg::IDX_CODE0, 32'h7F);
        end
        finish_test;
    end
endmodule
